// File: core/sao_map.svh
// Purpose: Register map, opcode patterns and counts for the subtract unit
// Assumes: 32-bit AXI4-Lite slave, byte addresses, low 8 address bits decoded
// Notes: Definitions only
`ifndef SAO_MAP_SVH
`define SAO_MAP_SVH

`define SAO_ADDR_ACC 8'h00
`define SAO_ADDR_INSTR 8'h04
`define SAO_ADDR_STATUS 8'h08
`define SAO_ADDR_FADDR 8'h0C
`define SAO_ADDR_FDATA 8'h10
`define SAO_ADDR_WDT 8'h14

`define SAO_ST_CARRY 0
`define SAO_ST_DIGIT 1
`define SAO_ST_ZERO 2
`define SAO_ST_PD 3
`define SAO_ST_TO 4
`define SAO_ST_HALT 5
`define SAO_ST_WAKE 6

`define SAO_OPC_LIT_MASK 14'h3E00
`define SAO_OPC_LIT_VAL 14'h3C00
`define SAO_OPC_FILE_MASK 14'h3F00
`define SAO_OPC_FILE_VAL 14'h0200
`define SAO_OPC_SLEEP 14'h0063
`define SAO_OPC_DEST_BIT 7

`define SAO_PRESCALE_LAST 8'hFF
`define SAO_WDT_LAST 8'hFF
`define SAO_RESP_OKAY 2'h0
`define SAO_RESP_SLVERR 2'h2

`endif

// File: core/sao_pkg.sv
// Purpose: Types shared by the subtract unit files
// Assumes: Constants live in sao_map.svh
// Notes: None
package sao_pkg;
	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
	} sao_flags_t;

	typedef enum logic [1:0] {
		sao_op_none,
		sao_op_lit,
		sao_op_file,
		sao_op_sleep
	} sao_op_t;
endpackage

// File: core/sao_subtractor.sv
// Purpose: 8-bit minuend minus subtrahend with carry, digit carry and zero
// Assumes: Carry is the inverted borrow
// Notes: Purely combinational
`timescale 1ns/1ps
module sao_subtractor (
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	output logic [7:0] difference,
	output sao_pkg::sao_flags_t flags
);
	import sao_pkg::*;
	logic [8:0] full;
	logic [4:0] low;

	// Add the inverse plus one so bit 8 is directly the no-borrow carry
	assign full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
	assign low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
	assign difference = full[7:0];
	assign flags.carry = full[8];
	assign flags.digit_carry = low[4];
	assign flags.zero = (full[7:0] == 8'h00);
endmodule

// File: core/sao_top.sv
// Purpose: Subtract instruction datapath with standby, reached over AXI4-Lite
// Assumes: One write and one read outstanding at most; 128-byte file space
// Notes: Writing the instruction register executes the opcode at once unless halted, when it is only stored
`timescale 1ns/1ps
`include "sao_map.svh"
module sao_top (
	input wire logic clock,
	input wire logic reset,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] acc_out,
	output logic halted
);
	import sao_pkg::*;

	logic [7:0] acc_q;
	logic [13:0] instr_q;
	sao_flags_t flags_q;
	logic powerdown_flag_q;
	logic timeout_flag_q;
	logic halted_q;
	logic [6:0] faddr_q;
	logic [7:0] file_q [0:127];
	logic [7:0] prescale_q;
	logic [7:0] wdt_q;

	logic [7:0] aw_addr_q;
	logic aw_full_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_full_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic awready_q;
	logic wready_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	logic do_write;
	logic [13:0] instr_d;
	logic exec;
	sao_op_t op;
	logic [7:0] minuend;
	logic [7:0] diff;
	sao_flags_t diff_flags;
	logic dest_file;
	logic pre_tick;
	logic wdt_expire;
	logic known_waddr;

	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign known_waddr = (aw_addr_q == `SAO_ADDR_ACC) || (aw_addr_q == `SAO_ADDR_INSTR) ||
		(aw_addr_q == `SAO_ADDR_STATUS) || (aw_addr_q == `SAO_ADDR_FADDR) ||
		(aw_addr_q == `SAO_ADDR_FDATA) || (aw_addr_q == `SAO_ADDR_WDT);
	assign instr_d = {w_strb_q[1] ? w_data_q[13:8] : instr_q[13:8],
		w_strb_q[0] ? w_data_q[7:0] : instr_q[7:0]};
	// A halted core executes nothing until woken
	assign exec = do_write && (aw_addr_q == `SAO_ADDR_INSTR) && !halted_q;

	always_comb begin
		op = sao_op_none;
		if (exec) begin
			if ((instr_d & `SAO_OPC_LIT_MASK) == `SAO_OPC_LIT_VAL) begin
				op = sao_op_lit;
			end else if ((instr_d & `SAO_OPC_FILE_MASK) == `SAO_OPC_FILE_VAL) begin
				op = sao_op_file;
			end else if (instr_d == `SAO_OPC_SLEEP) begin
				op = sao_op_sleep;
			end
		end
	end

	assign dest_file = instr_d[`SAO_OPC_DEST_BIT];
	// Literal opcode subtracts from the literal, file opcode from the register
	assign minuend = (op == sao_op_lit) ? instr_d[7:0] : file_q[instr_d[6:0]];

	sao_subtractor u_sub (
		.minuend(minuend),
		.subtrahend(acc_q),
		.difference(diff),
		.flags(diff_flags)
	);

	assign pre_tick = (prescale_q == `SAO_PRESCALE_LAST);
	assign wdt_expire = pre_tick && (wdt_q == `SAO_WDT_LAST);

	// Write channel capture
	always_ff @(posedge clock) begin
		if (reset) begin
			aw_full_q <= 1'b0;
			awready_q <= 1'b1;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && awready_q) begin
			aw_full_q <= 1'b1;
			awready_q <= 1'b0;
			aw_addr_q <= s_axi_awaddr[7:0];
		end else if (do_write) begin
			aw_full_q <= 1'b0;
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			w_full_q <= 1'b0;
			wready_q <= 1'b1;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && wready_q) begin
			w_full_q <= 1'b1;
			wready_q <= 1'b0;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_q <= 1'b0;
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			bvalid_q <= 1'b0;
			bresp_q <= `SAO_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= known_waddr ? `SAO_RESP_OKAY : `SAO_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Accumulator
	always_ff @(posedge clock) begin
		if (reset) begin
			acc_q <= 8'h00;
		end else if (op == sao_op_lit) begin
			acc_q <= diff;
		end else if (op == sao_op_file && !dest_file) begin
			acc_q <= diff;
		end else if (do_write && aw_addr_q == `SAO_ADDR_ACC && w_strb_q[0]) begin
			acc_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			instr_q <= 14'h0000;
		end else if (do_write && aw_addr_q == `SAO_ADDR_INSTR) begin
			instr_q <= instr_d;
		end
	end

	// File space; array has no reset, as a real register file would not
	always_ff @(posedge clock) begin
		if (op == sao_op_file && dest_file) begin
			file_q[instr_d[6:0]] <= diff;
		end else if (do_write && aw_addr_q == `SAO_ADDR_FDATA && w_strb_q[0]) begin
			file_q[faddr_q] <= w_data_q[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			faddr_q <= 7'h00;
		end else if (do_write && aw_addr_q == `SAO_ADDR_FADDR && w_strb_q[0]) begin
			faddr_q <= w_data_q[6:0];
		end
	end

	// Arithmetic flags
	always_ff @(posedge clock) begin
		if (reset) begin
			flags_q <= '0;
		end else if (op == sao_op_lit || op == sao_op_file) begin
			flags_q <= diff_flags;
		end else if (do_write && aw_addr_q == `SAO_ADDR_STATUS && w_strb_q[0]) begin
			flags_q.carry <= w_data_q[`SAO_ST_CARRY];
			flags_q.digit_carry <= w_data_q[`SAO_ST_DIGIT];
			flags_q.zero <= w_data_q[`SAO_ST_ZERO];
		end
	end

	// Power flags; both read as one after reset
	always_ff @(posedge clock) begin
		if (reset) begin
			powerdown_flag_q <= 1'b1;
			timeout_flag_q <= 1'b1;
		end else if (op == sao_op_sleep) begin
			powerdown_flag_q <= 1'b0;
			timeout_flag_q <= 1'b1;
		end else if (wdt_expire) begin
			timeout_flag_q <= 1'b0;
		end
	end

	// Halt stands for the stopped oscillator; watchdog expiry or software wakes
	always_ff @(posedge clock) begin
		if (reset) begin
			halted_q <= 1'b0;
		end else if (op == sao_op_sleep) begin
			halted_q <= 1'b1;
		end else if (wdt_expire) begin
			halted_q <= 1'b0;
		end else if (do_write && aw_addr_q == `SAO_ADDR_STATUS && w_strb_q[0] &&
			w_data_q[`SAO_ST_WAKE]) begin
			halted_q <= 1'b0;
		end
	end

	// Watchdog runs from its own prescaler, also while halted
	always_ff @(posedge clock) begin
		if (reset || op == sao_op_sleep) begin
			prescale_q <= 8'h00;
		end else begin
			prescale_q <= prescale_q + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || op == sao_op_sleep) begin
			wdt_q <= 8'h00;
		end else if (pre_tick) begin
			wdt_q <= wdt_q + 8'h01;
		end
	end

	// Read channel
	always_ff @(posedge clock) begin
		if (reset) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `SAO_RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= `SAO_RESP_OKAY;
			unique case (s_axi_araddr[7:0])
				`SAO_ADDR_ACC: rdata_q <= {24'h000000, acc_q};
				`SAO_ADDR_INSTR: rdata_q <= {18'h00000, instr_q};
				`SAO_ADDR_STATUS: rdata_q <= {26'h0000000, halted_q, timeout_flag_q,
					powerdown_flag_q, flags_q.zero, flags_q.digit_carry, flags_q.carry};
				`SAO_ADDR_FADDR: rdata_q <= {25'h0000000, faddr_q};
				`SAO_ADDR_FDATA: rdata_q <= {24'h000000, file_q[faddr_q]};
				`SAO_ADDR_WDT: rdata_q <= {24'h000000, wdt_q};
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= `SAO_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign acc_out = acc_q;
	assign halted = halted_q;
endmodule

// File: testbench/sao_bus_model.sv
// Purpose: Bus master standing in for the decoder side
// Assumes: Tasks are entered just after a rising edge
// Notes: Ready rises a cycle late so responses must stand
`timescale 1ns/1ps
module sao_bus_model (
	input wire logic clock,
	output logic [31:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [31:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			// One assignment to bready per edge: raise on seeing bvalid, drop once taken
			done = s_axi_bvalid && s_axi_bready;
			if (s_axi_bvalid) s_axi_bready <= !done;
		end while (!done);
		r = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			done = s_axi_rvalid && s_axi_rready;
			if (s_axi_rvalid) s_axi_rready <= !done;
		end while (!done);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule

// File: testbench/sao_top_asserts.sv
// Purpose: Bus timing checks on the subtract unit ports
// Assumes: One clock domain
// Notes: Flag and result values are judged by the bench
`timescale 1ns/1ps
module sao_top_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [7:0] acc_out,
	input wire logic halted
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (both_taken |=> ##1 s_axi_bvalid)
		else $error("write response late");
	read_answer_a: assert property (read_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data moved");
	rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address taken twice");
	w_block_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("data taken twice");
	acc_cause_a: assert property ($changed(acc_out) |-> $rose(s_axi_bvalid))
		else $error("accumulator changed without a write");
	halt_cause_a: assert property ($rose(halted) |-> $rose(s_axi_bvalid))
		else $error("halt without a write");
endmodule
bind sao_top sao_top_asserts sao_top_asserts_inst (.*);

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the subtract unit
// Assumes: File address 5 is used as the file operand
// Notes: Expected flags use the no-borrow carry form
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] acc_out;
	logic halted;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 clock = ~clock;
	sao_top sao_top_inst (.*);
	sao_bus_model bus (.*);
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic sub_case(input logic lit, input logic [7:0] w, m, input logic d);
		logic [7:0] e;
		logic [31:0] v;
		logic [1:0] r;
		e = m - w;
		bus.wr(8'h0C, 32'h5, r);
		bus.wr(8'h10, {24'h0, m}, r);
		bus.wr(8'h00, {24'h0, w}, r);
		bus.wr(8'h04, lit ? {23'h1E, d, m} : {24'h02, d, 7'h05}, r);
		chk("instr resp", 0, r);
		bus.rd(8'h00, v, r);
		chk("accumulator", (lit || !d) ? e : w, v);
		chk("acc port", (lit || !d) ? e : w, acc_out);
		bus.rd(8'h10, v, r);
		chk("file", (!lit && d) ? e : m, v);
		bus.rd(8'h08, v, r);
		chk("flags", {e == 8'h0, m[3:0] >= w[3:0], m >= w}, v[2:0]);
	endtask
	task t_literal;
		sub_case(1'b1, 8'h01, 8'h02, 1'b0);
		sub_case(1'b1, 8'h02, 8'h02, 1'b1);
		sub_case(1'b1, 8'h03, 8'h02, 1'b0);
	endtask
	task t_file;
		sub_case(1'b0, 8'h02, 8'h03, 1'b1);
		sub_case(1'b0, 8'h02, 8'h02, 1'b1);
		sub_case(1'b0, 8'h02, 8'h01, 1'b0);
		sub_case(1'b0, 8'h18, 8'h21, 1'b1);
	endtask
	task automatic t_standby;
		logic [31:0] v;
		logic [1:0] r;
		int n;
		bus.wr(8'h04, 32'h63, r);
		chk("halted", 1, halted);
		bus.rd(8'h08, v, r);
		chk("standby status", 3'b110, v[5:3]);
		bus.rd(8'h14, v, r);
		chk("watchdog", 0, v);
		// Opcode while halted is stored only; acc keeps 0x18 from the last file case
		bus.wr(8'h04, 32'h3C05, r);
		chk("halted exec", 8'h18, acc_out);
		// Expiry is the only way to clear timeout, so the next standby can show it set
		for (n = 0; n < 66000 && halted; n++) begin
			@(posedge clock);
		end
		chk("expired", 0, halted);
		chk("expiry early", 1, n > 65000);
		bus.rd(8'h08, v, r);
		chk("expired status", 3'b000, v[5:3]);
		bus.wr(8'h04, 32'h63, r);
		bus.rd(8'h08, v, r);
		chk("timeout set", 3'b110, v[5:3]);
		bus.wr(8'h08, 32'h40, r);
		chk("awake", 0, halted);
	endtask
	task automatic t_unmapped;
		logic [31:0] v;
		logic [1:0] r;
		bus.wr(8'h20, 32'h1, r);
		chk("write resp", 2, r);
		bus.rd(8'h20, v, r);
		chk("read resp", 2, r);
		chk("read data", 0, v);
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		// One watchdog period dominates the run
		if (cycles == 90000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_literal();
		t_file();
		t_standby();
		t_unmapped();
		test_done;
	end
endmodule
